//--- shared/rct_pkg.sv
package rct_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] RCT_IDX_CTRL    = 8'hac;
	localparam logic [7:0] RCT_IDX_CSR     = 8'had;
	localparam logic [7:0] RCT_IDX_COUNT   = 8'hae;
	localparam logic [7:0] RCT_IDX_COMPARE = 8'haf;

	localparam int RCT_AW = 12;

	// Field positions in the control/status register.
	localparam int RCT_CSR_FLAG  = 7;
	localparam int RCT_CSR_IRQEN = 6;
	localparam int RCT_CSR_SELHI = 5;
	localparam int RCT_CSR_SELLO = 3;
	localparam logic [2:0] RCT_CSR_RSVD = 3'h7;

	// Field positions in the refresh control register.
	localparam int RCT_CTL_SRF   = 7;
	localparam int RCT_CTL_PSRAM = 6;
	localparam int RCT_CTL_DRAM  = 5;

	// Reset values and the divide-by-two select code.
	localparam logic [7:0] RCT_COUNT_RST   = 8'h00;
	localparam logic [7:0] RCT_COMPARE_RST = 8'hff;
	localparam logic [2:0] RCT_SEL_STOP    = 3'h0;
	localparam logic [2:0] RCT_SEL_DIV2    = 3'h1;

	// Prescaler width: the largest division is 4096.
	localparam int RCT_DIV_W = 12;

	// Mask of divider bits that must all be one for a tick at the selected rate.
	function automatic logic [RCT_DIV_W-1:0] rct_div_mask(input logic [2:0] sel);
		logic [RCT_DIV_W-1:0] m;
		m = 12'h000;
		case (sel)
			3'h1: m = 12'h001;
			3'h2: m = 12'h007;
			3'h3: m = 12'h01f;
			3'h4: m = 12'h07f;
			3'h5: m = 12'h1ff;
			3'h6: m = 12'h7ff;
			3'h7: m = 12'hfff;
			default: m = 12'h000;
		endcase
		return m;
	endfunction

	// Byte address of a register index: four times the index.
	function automatic logic [RCT_AW-1:0] rct_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

endpackage

//--- shared/rct_tick_if.sv
interface rct_tick_if;
	logic [2:0] sel;
	logic       tick;

	// The timer picks the rate, the prescaler answers with enable pulses.
	modport timer (output sel, input tick);
	modport prescaler (input sel, output tick);
endinterface

//--- hw/rct_prescaler.sv
module rct_prescaler
	import rct_pkg::*;
(
	// Clock and reset.
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Rate selection and tick.
	rct_tick_if.prescaler  tk
);
	import rct_pkg::*;

	typedef struct packed {
		logic [RCT_DIV_W-1:0] div;
	} rct_pre_s;

	rct_pre_s state_reg;
	rct_pre_s state_next;

	// Free-running divider; its phase is kept when the rate changes.
	always_comb begin
		state_next     = state_reg;
		state_next.div = state_reg.div + 12'h001;
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// A tick is one cycle when the selected low bits are all ones; it follows the current
	// select, so a stop takes effect at once and no stray tick follows it.
	assign tk.tick = (tk.sel != RCT_SEL_STOP) &&
		((state_reg.div & rct_div_mask(tk.sel)) == rct_div_mask(tk.sel));

endmodule

//--- hw/rct_top.sv
// Contract
// - Count equal to compare constant clears count and sets the match flag.
// - Flag clears only by reading it as 1, then writing 0.
// - Writing 1 to the match flag has no effect.
// - Self-refresh bit enables memory self-refresh during software standby; the request is raised only in DRAM or PSRAM mode.
// - Both memory enables 0 means plain interval timer; both 1 is illegal.
//
// Register access over APB is this design's own decision.
module rct_top
	import rct_pkg::*;
(
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [RCT_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// System status.
	input  wire logic              sw_standby,
	// Timer and refresh outputs.
	output logic                   match_irq,
	output logic                   self_refresh_req,
	output logic                   interval_mode,
	output logic                   dram_mode,
	output logic                   psram_mode,
	output logic                   ram_cfg_illegal
);
	import rct_pkg::*;

	typedef struct packed {
		logic [7:0]  refresh_count;
		logic [7:0]  refresh_compare_constant;
		logic        match_flag;
		logic        match_irq_en;
		logic [2:0]  prescale_sel;
		logic        clear_armed;
		logic        self_refresh_en;
		logic        pseudo_static_ram_en;
		logic        dynamic_ram_en;
		logic [31:0] rdata;
	} rct_state_s;

	rct_state_s state_reg;
	rct_state_s state_next;

	rct_tick_if tk ();

	// Bus decode, match and memory setting terms.
	logic setup_cyc;
	logic access_cyc;
	logic wr_en;
	logic rd_done;
	logic hit_ctrl;
	logic hit_csr;
	logic hit_count;
	logic hit_compare;
	logic mapped;
	logic match_now;
	logic ram_illegal;

	// Counter clock enables come from the prescaler.
	rct_prescaler u_prescaler (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk.prescaler)
	);

	assign tk.sel = state_reg.prescale_sel;

	// Address decode.
	always_comb begin
		hit_ctrl    = 1'b0;
		hit_csr     = 1'b0;
		hit_count   = 1'b0;
		hit_compare = 1'b0;
		if (paddr == rct_addr(RCT_IDX_CTRL)) begin
			hit_ctrl = 1'b1;
		end else if (paddr == rct_addr(RCT_IDX_CSR)) begin
			hit_csr = 1'b1;
		end else if (paddr == rct_addr(RCT_IDX_COUNT)) begin
			hit_count = 1'b1;
		end else if (paddr == rct_addr(RCT_IDX_COMPARE)) begin
			hit_compare = 1'b1;
		end
	end

	// Read data is captured in the setup cycle, so every access ends with no wait.
	assign mapped     = hit_ctrl | hit_csr | hit_count | hit_compare;
	assign setup_cyc  = psel & ~penable;
	assign access_cyc = psel & penable;
	assign wr_en      = access_cyc & pwrite & mapped;
	assign rd_done    = access_cyc & ~pwrite & hit_csr;
	assign pready     = 1'b1;
	assign pslverr    = access_cyc & ~mapped;
	assign prdata     = state_reg.rdata;

	// A match is seen on a counter tick when the count has reached the constant.
	assign match_now = tk.tick &&
		(state_reg.refresh_count == state_reg.refresh_compare_constant);
	assign ram_illegal = state_reg.pseudo_static_ram_en & state_reg.dynamic_ram_en;

	// Next-state logic for registers, counter and flag.
	always_comb begin
		state_next = state_reg;

		// Read mux, loaded in the setup phase; unmapped addresses read zero.
		if (setup_cyc && !pwrite) begin
			state_next.rdata = 32'h0000_0000;
			if (hit_ctrl) begin
				state_next.rdata[RCT_CTL_SRF]   = state_reg.self_refresh_en;
				state_next.rdata[RCT_CTL_PSRAM] = state_reg.pseudo_static_ram_en;
				state_next.rdata[RCT_CTL_DRAM]  = state_reg.dynamic_ram_en;
			end else if (hit_csr) begin
				state_next.rdata[RCT_CSR_FLAG]  = state_reg.match_flag;
				state_next.rdata[RCT_CSR_IRQEN] = state_reg.match_irq_en;
				state_next.rdata[RCT_CSR_SELHI:RCT_CSR_SELLO] = state_reg.prescale_sel;
				state_next.rdata[RCT_CSR_SELLO-1:0] = RCT_CSR_RSVD;
			end else if (hit_count) begin
				state_next.rdata[7:0] = state_reg.refresh_count;
			end else if (hit_compare) begin
				state_next.rdata[7:0] = state_reg.refresh_compare_constant;
			end
		end

		// A completed read that returned the flag as 1 arms the clear.
		if (rd_done && state_reg.rdata[RCT_CSR_FLAG]) begin
			state_next.clear_armed = 1'b1;
		end

		// Counting: stop select gives no ticks, a match clears the count.
		if (match_now) begin
			state_next.refresh_count = RCT_COUNT_RST;
		end else if (tk.tick) begin
			state_next.refresh_count = state_reg.refresh_count + 8'h01;
		end

		// Register writes; a software write to the count wins over a tick.
		if (wr_en && hit_ctrl) begin
			state_next.self_refresh_en      = pwdata[RCT_CTL_SRF];
			state_next.pseudo_static_ram_en = pwdata[RCT_CTL_PSRAM];
			state_next.dynamic_ram_en       = pwdata[RCT_CTL_DRAM];
		end else if (wr_en && hit_csr) begin
			state_next.match_irq_en = pwdata[RCT_CSR_IRQEN];
			state_next.prescale_sel = pwdata[RCT_CSR_SELHI:RCT_CSR_SELLO];
			// Only a 0 written after an armed read clears; a 1 never sets.
			if (state_reg.clear_armed && !pwdata[RCT_CSR_FLAG]) begin
				state_next.match_flag = 1'b0;
			end
			state_next.clear_armed = 1'b0;
		end else if (wr_en && hit_count) begin
			state_next.refresh_count = pwdata[7:0];
		end else if (wr_en && hit_compare) begin
			state_next.refresh_compare_constant = pwdata[7:0];
		end

		// A match in the same cycle as the clear keeps the flag set.
		if (match_now) begin
			state_next.match_flag = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.refresh_count            <= RCT_COUNT_RST;
			state_reg.refresh_compare_constant <= RCT_COMPARE_RST;
			state_reg.match_flag               <= 1'b0;
			state_reg.match_irq_en             <= 1'b0;
			state_reg.prescale_sel             <= RCT_SEL_STOP;
			state_reg.clear_armed              <= 1'b0;
			state_reg.self_refresh_en          <= 1'b0;
			state_reg.pseudo_static_ram_en     <= 1'b0;
			state_reg.dynamic_ram_en           <= 1'b0;
			state_reg.rdata                    <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	// Interrupt request and memory refresh mode outputs.
	assign match_irq        = state_reg.match_flag & state_reg.match_irq_en;
	assign interval_mode    = ~state_reg.pseudo_static_ram_en & ~state_reg.dynamic_ram_en;
	assign ram_cfg_illegal  = ram_illegal;
	assign dram_mode        = state_reg.dynamic_ram_en & ~ram_illegal;
	assign psram_mode       = state_reg.pseudo_static_ram_en & ~ram_illegal;
	// Self-refresh is only asked for while in standby with a legal memory type.
	assign self_refresh_req = sw_standby & state_reg.self_refresh_en & (dram_mode | psram_mode);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A match sets the flag and clears the count on the next edge.
	chk_match_sets_flag: assert property (
		(match_now && !(wr_en && hit_count)) |=> (state_reg.match_flag && state_reg.refresh_count == RCT_COUNT_RST))
		else $error("match did not set flag and clear count");

	// While the stop select is set and no write occurs, the count holds.
	chk_stop_holds: assert property (
		(state_reg.prescale_sel == RCT_SEL_STOP && !wr_en) |=> $stable(state_reg.refresh_count))
		else $error("count moved while stopped");

	// At divide-by-two the ticks alternate while the rate is held.
	chk_div2_rate: assert property (
		(tk.sel == RCT_SEL_DIV2 && tk.tick ##1 tk.sel == RCT_SEL_DIV2 ##1 tk.sel == RCT_SEL_DIV2)
		|-> (tk.tick && !$past(tk.tick)))
		else $error("divide by two rate wrong");

	// The flag cannot fall unless the clear was armed by a read.
	chk_flag_needs_read: assert property (
		(state_reg.match_flag && !state_reg.clear_armed) |=> state_reg.match_flag)
		else $error("flag cleared without prior read");

	// An armed clear with a written 0 drops the flag unless a match arrives.
	chk_flag_clear: assert property (
		(state_reg.clear_armed && wr_en && hit_csr && !pwdata[RCT_CSR_FLAG] && !match_now)
		|=> !state_reg.match_flag)
		else $error("armed clear ignored");

	// Writing 1 never sets the flag.
	chk_one_no_set: assert property (
		(!state_reg.match_flag && !match_now) |=> !state_reg.match_flag)
		else $error("flag set without match");

	// Request follows flag and enable.
	chk_irq_follows: assert property (
		$rose(state_reg.match_flag) |-> (match_irq == state_reg.match_irq_en))
		else $error("interrupt request does not follow flag");

	// Self-refresh only in standby with the enable bit on.
	chk_selfref_gate: assert property (
		self_refresh_req |-> (sw_standby && state_reg.self_refresh_en && !ram_cfg_illegal))
		else $error("self refresh outside standby or enable");

	// Illegal memory setting gives no memory mode.
	chk_illegal_ram: assert property (
		(state_reg.pseudo_static_ram_en && state_reg.dynamic_ram_en)
		|-> (ram_cfg_illegal && !dram_mode && !psram_mode && !interval_mode))
		else $error("illegal memory setting not flagged");

	// A tick with no match and no count write steps the count by one.
	chk_count_step: assert property (
		(tk.tick && !match_now && !(wr_en && hit_count))
		|=> (state_reg.refresh_count == $past(state_reg.refresh_count) + 8'h01))
		else $error("count did not step on tick");

	// The stop select gives no ticks at all.
	chk_stop_no_tick: assert property (
		(tk.sel == RCT_SEL_STOP) |-> !tk.tick)
		else $error("tick while stopped");

	// Ticks are single-cycle pulses at every rate.
	chk_tick_single: assert property (
		tk.tick |=> !tk.tick)
		else $error("tick longer than one cycle");

	// No match can happen while the counter is stopped.
	chk_no_match_stop: assert property (
		(tk.sel == RCT_SEL_STOP) |-> !match_now)
		else $error("match while stopped");

	// A completed read that returned the flag as 1 arms the clear.
	chk_arm_on_read: assert property (
		(rd_done && state_reg.rdata[RCT_CSR_FLAG]) |=> state_reg.clear_armed)
		else $error("read of set flag did not arm clear");

	// Any write to the control/status register disarms the clear.
	chk_disarm_on_write: assert property (
		(wr_en && hit_csr) |=> !state_reg.clear_armed)
		else $error("clear still armed after write");

	// Writing 1 to the flag leaves it as it was.
	chk_one_keeps_flag: assert property (
		(wr_en && hit_csr && pwdata[RCT_CSR_FLAG] && !match_now)
		|=> (state_reg.match_flag == $past(state_reg.match_flag)))
		else $error("write of one changed the flag");

	// No request without both the flag and the enable.
	chk_irq_needs_flag: assert property (
		match_irq |-> (state_reg.match_flag && state_reg.match_irq_en))
		else $error("interrupt request without flag and enable");

	// Flag and enable together always raise the request.
	chk_irq_when_set: assert property (
		(state_reg.match_flag && state_reg.match_irq_en) |-> match_irq)
		else $error("interrupt request missing");

	// Both memory enables clear give the plain interval timer.
	chk_interval_mode: assert property (
		(!state_reg.pseudo_static_ram_en && !state_reg.dynamic_ram_en)
		|-> (interval_mode && !ram_cfg_illegal && !dram_mode && !psram_mode))
		else $error("interval mode not shown");

	// A write to the refresh control register lands the self-refresh bit.
	chk_ctrl_write: assert property (
		(wr_en && hit_ctrl) |=> (state_reg.self_refresh_en == $past(pwdata[RCT_CTL_SRF])))
		else $error("self refresh bit not written");

	// Standby with the enable and a legal memory type asks for self-refresh.
	chk_selfref_on: assert property (
		(sw_standby && state_reg.self_refresh_en && (dram_mode || psram_mode)) |-> self_refresh_req)
		else $error("self refresh not requested");

endmodule

//--- verification/rct_top_test.sv
module rct_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rct_pkg::*;

	logic              pclk = 1'b0;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [RCT_AW-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              sw_standby;
	wire  [5:0]        outs;
	logic              noted;
	logic [32:0]       exp_q[$];
	logic [31:0]       seed = 32'h5675;
	logic [31:0]       c1;
	logic [31:0]       c2;
	int                num_errors = 0;
	int                samples_checked = 0;
	int                divs[8] = '{1, 2, 8, 32, 128, 512, 2048, 4096};

	// Clock at 50 ns period.
	always #25 pclk = ~pclk;

	rct_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sw_standby(sw_standby), .match_irq(outs[5]), .self_refresh_req(outs[4]), .interval_mode(outs[3]),
		.dram_mode(outs[2]), .psram_mode(outs[1]), .ram_cfg_illegal(outs[0]));

	// Xorshift source for the unused upper write bits.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic wrap_up();
		$display("counts: %0d checked, %0d mismatches", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, e, s);
		end
	endtask

	task automatic check_rd(input logic [32:0] e);
		samples_checked++;
		if ({pslverr, prdata} !== e) begin
			num_errors++;
			$display("mismatch read expected %h seen %h", e, {pslverr, prdata});
		end
	endtask

	// One APB transfer, entered just after a rising edge; ends one edge after release.
	task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd, input logic nt,
		output logic [31:0] rd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= rct_addr(idx);
		pwdata <= wd;
		noted <= nt;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			num_errors++;
			wrap_up();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] r;
		logic [31:0] d;
		r = rnd();
		apb(idx, 1'b1, {r[31:8], v}, 1'b0, d);
	endtask

	task automatic rd_exp(input logic [7:0] idx, input logic [32:0] e);
		logic [31:0] d;
		exp_q.push_back(e);
		apb(idx, 1'b0, 32'h0, 1'b1, d);
	endtask

	task automatic rd_val(input logic [7:0] idx, output logic [31:0] d);
		apb(idx, 1'b0, 32'h0, 1'b0, d);
	endtask

	task automatic chk_out(input logic [5:0] e, input logic [5:0] m);
		@(negedge pclk);
		check_val("outputs", {26'h0, e & m}, {26'h0, outs & m});
		@(posedge pclk);
	endtask

	// Takes the oldest noted read result at each completed read.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && noted && exp_q.size() > 0) begin
			check_rd(exp_q.pop_front());
		end
	end

	// Main sequence.
	initial begin
		int n;
		{presetn, psel, penable, pwrite, noted, sw_standby} = 6'h0;
		paddr = '0;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_exp(RCT_IDX_COUNT, 33'h0);
		rd_exp(RCT_IDX_COMPARE, 33'hff);
		rd_exp(RCT_IDX_CSR, 33'h7);
		rd_exp(RCT_IDX_CTRL, 33'h0);
		wr(8'h00, 8'hff);
		rd_exp(8'h00, 33'h1_0000_0000);
		chk_out(6'h08, 6'h3f);
		$display("test reset done");
		// Count steps over a window of four ticks at each rate; stopped gives none.
		for (int s = 0; s < 8; s++) begin
			wr(RCT_IDX_CSR, {2'h0, s[2:0], 3'h0});
			wr(RCT_IDX_COUNT, 8'h00);
			rd_val(RCT_IDX_COUNT, c1);
			repeat (4 * divs[s] - 3) @(posedge pclk);
			rd_val(RCT_IDX_COUNT, c2);
			check_val("count step", (s == 0) ? 32'h0 : 32'h4, c2 - c1);
		end
		$display("test rates done");
		// Compare 3 at clock/2: count wraps every 8 cycles.
		wr(RCT_IDX_COMPARE, 8'h03);
		wr(RCT_IDX_COUNT, 8'h00);
		wr(RCT_IDX_CSR, 8'h48);
		rd_val(RCT_IDX_COUNT, c1);
		repeat (13) @(posedge pclk);
		rd_val(RCT_IDX_COUNT, c2);
		check_val("count period", c1, c2);
		check_val("count bound", 32'h1, {31'h0, c1 <= 32'h3});
		n = 0;
		while (outs[5] !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (n == 100) begin
			num_errors++;
			wrap_up();
		end
		wr(RCT_IDX_CSR, 8'h40);
		chk_out(6'h28, 6'h3f);
		wr(RCT_IDX_CSR, 8'h00);
		chk_out(6'h08, 6'h3f);
		rd_exp(RCT_IDX_CSR, 33'h87);
		wr(RCT_IDX_CSR, 8'h40);
		chk_out(6'h08, 6'h3f);
		wr(RCT_IDX_CSR, 8'hc0);
		rd_exp(RCT_IDX_CSR, 33'h47);
		$display("test match flag done");
		// Every memory setting with and without standby.
		for (int i = 0; i < 16; i++) begin
			sw_standby <= i[3];
			wr(RCT_IDX_CTRL, {i[2:0], 5'h0});
			rd_exp(RCT_IDX_CTRL, {25'h0, i[2:0], 5'h0});
			chk_out({2'b00, i[1:0] == 2'b00, i[0] & ~i[1], i[1] & ~i[0], i[1] & i[0]}, 6'h0f);
			if (i[2:1] != 2'b00) begin
				chk_out({1'b0, i[3] & i[2] & (i[1] ^ i[0]), 4'h0}, 6'h10);
			end
		end
		$display("test memory modes done");
		wrap_up();
	end
endmodule
